// *** rtl/timer_output_compare.sv ***
// output compare and single pulse section of a 16-bit timer

//Contract
//- compare both values to counter every cycle
//- compare values reset to 8000h
//- compare values software owned, hardware never changes
//- match with pin enable drives level
//- compare pin latches low during reset
//- interrupt needs enable and cleared mask
//- pin disabled: no level, interrupt allowed
//- flag clears: flag read then low access
//- high byte write inhibits compare
//- low byte write re-enables, clears flag
//- flag and pin set while equal
//- force copies level, no flag, no interrupt
//- force ignored in pulse or width modes
//- control two bit selects single pulse
//- trigger edge: load counter, pulse level, capture
//- trigger capture flag may raise interrupt
//- match one ends pulse with post level
//- single pulse: flag one never set
//- width mode overrides single pulse mode
//- single pulse: capture one not ordinary capture
//- single pulse: compare two drives no pin
module timer_output_compare (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [15:0] counter_i,
  input  wire logic        cpu_irq_mask_i,
  input  wire logic        capture_input_one_i,
  input  wire logic        capture_input_two_i,
  output logic      [1:0]  compare_output_pin_o,
  output logic      [1:0]  compare_output_oe_o,
  output logic             counter_load_o,
  output logic             timer_irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic        ack;           // bus answer
  logic [31:0] rd_q;          // read data register
  logic [7:0]  ctrl_one;      // timer_control_one
  logic [7:0]  ctrl_two;      // timer_control_two
  logic [15:0] cmp_val [2];   // compare_value_reg per function
  logic [1:0]  inhibit;       // high byte written, low pending
  logic [1:0]  cmp_armed;     // flag read while set
  logic [1:0]  cmp_flag;      // compare_flag per function
  logic [1:0]  pin_q;         // compare pin latches
  logic [15:0] cap_val [2];   // capture_value per function
  logic [1:0]  cap_armed;     // capture flag read while set
  logic [1:0]  cap_flag;      // capture_flag per function
  logic        load_q;        // counter reload pulse
  logic        irq_q;         // timer interrupt request

  // ---------------------------------------------------------------
  // capture pin synchroniser
  // ---------------------------------------------------------------
  capture_edge_if cap_edges ();

  pin_edge_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({capture_input_two_i, capture_input_one_i}),
    .edges (cap_edges)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire bus_req  = cyc_i & stb_i;           // request present
  wire bus_take = bus_req & ack;           // edge where access acts
  wire bus_wr   = bus_take & we_i & sel_i[0];
  wire bus_rd   = bus_take & ~we_i;
  wire flag_rd  = bus_rd & (adr_i == timer_oc_pkg::FLAG_OFF);
  wire ctrl_one_wr = bus_wr & (adr_i == timer_oc_pkg::CTRL_ONE_OFF);
  wire ctrl_two_wr = bus_wr & (adr_i == timer_oc_pkg::CTRL_TWO_OFF);

  // ---------------------------------------------------------------
  // mode and field decode
  // ---------------------------------------------------------------
  wire pwm_on = ctrl_two[timer_oc_pkg::PWM_BIT];
  // width mode wins when both mode bits are set
  wire pulse_mode = ctrl_two[timer_oc_pkg::SINGLE_PULSE_BIT] & ~pwm_on;
  wire [1:0] level  = {ctrl_one[timer_oc_pkg::LVL_TWO_BIT],
                       ctrl_one[timer_oc_pkg::LVL_ONE_BIT]};
  wire [1:0] pin_en = {ctrl_two[timer_oc_pkg::PIN_EN_TWO_BIT],
                       ctrl_two[timer_oc_pkg::PIN_EN_ONE_BIT]};
  wire [1:0] edge_sel = {ctrl_two[timer_oc_pkg::EDGE_TWO_BIT],
                         ctrl_one[timer_oc_pkg::EDGE_ONE_BIT]};
  wire cmp_irq_en = ctrl_one[timer_oc_pkg::CMP_IRQ_BIT];
  wire cap_irq_en = ctrl_one[timer_oc_pkg::CAP_IRQ_BIT];
  // force bits act on the write only, never stored
  wire force_ok = ctrl_one_wr & ~pulse_mode & ~pwm_on;
  // levels written together with the force bits are the ones copied
  wire [1:0] force_lvl = {dat_i[timer_oc_pkg::LVL_TWO_BIT],
                          dat_i[timer_oc_pkg::LVL_ONE_BIT]};
  wire [1:0] force_req = {2{force_ok}} &
                         {dat_i[timer_oc_pkg::FORCE_TWO_BIT],
                          dat_i[timer_oc_pkg::FORCE_ONE_BIT]};
  // active capture edges per pin
  wire [1:0] cap_ev = (edge_sel & cap_edges.rise) |
                      (~edge_sel & cap_edges.fall);
  wire pulse_trig = pulse_mode & cap_ev[0];

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // reserved and force bits are masked on the way in
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one <= timer_oc_pkg::CTRL_RESET;
      ctrl_two <= timer_oc_pkg::CTRL_RESET;
    end else begin
      if (ctrl_one_wr)
        ctrl_one <= dat_i[7:0] & timer_oc_pkg::CTRL_ONE_WMASK;
      if (ctrl_two_wr)
        ctrl_two <= dat_i[7:0] & timer_oc_pkg::CTRL_TWO_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // compare functions
  // ---------------------------------------------------------------
  logic [1:0] match;   // equal and not inhibited
  logic [1:0] hi_wr;   // high byte written
  logic [1:0] lo_wr;   // low byte written
  logic [1:0] lo_acc;  // low byte read or written
  logic [1:0] set_cmp; // hardware sets flag

  for (genvar g = 0; g < 2; g++) begin : g_cmp
    localparam logic [7:0] HI_OFF = (g == 0) ? timer_oc_pkg::CMP_ONE_HIGH_OFF
                                             : timer_oc_pkg::CMP_TWO_HIGH_OFF;
    localparam logic [7:0] LO_OFF = (g == 0) ? timer_oc_pkg::CMP_ONE_LOW_OFF
                                             : timer_oc_pkg::CMP_TWO_LOW_OFF;
    assign hi_wr[g]  = bus_wr & (adr_i == HI_OFF);
    assign lo_wr[g]  = bus_wr & (adr_i == LO_OFF);
    assign lo_acc[g] = bus_take & (adr_i == LO_OFF);
    // compared every cycle, true while the values are equal and the function is not inhibited
    assign match[g] = (counter_i == cmp_val[g]) & ~inhibit[g];
    // function one never flags in single pulse mode
    assign set_cmp[g] = match[g] & ~(g == 0 & pulse_mode);

    // value: only software writes it
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cmp_val[g] <= timer_oc_pkg::CMP_RESET;
      end else if (hi_wr[g]) begin
        cmp_val[g][15:8] <= dat_i[7:0];
      end else if (lo_wr[g]) begin
        cmp_val[g][7:0] <= dat_i[7:0];
      end
    end

    // high write holds compare off until the low write
    always_ff @(posedge clk_i) begin
      if (rst_i)
        inhibit[g] <= 1'b0;
      else if (hi_wr[g])
        inhibit[g] <= 1'b1;
      else if (lo_wr[g])
        inhibit[g] <= 1'b0;
    end

    // first clearing step: status read while flag set
    always_ff @(posedge clk_i) begin
      if (rst_i)
        cmp_armed[g] <= 1'b0;
      else if (flag_rd)
        cmp_armed[g] <= cmp_flag[g];
      else if (lo_acc[g])
        cmp_armed[g] <= 1'b0;
    end

    // sticky flag, a new match beats any clear
    always_ff @(posedge clk_i) begin
      if (rst_i)
        cmp_flag[g] <= 1'b0;
      else if (set_cmp[g])
        cmp_flag[g] <= 1'b1;
      else if (lo_wr[g] | (lo_acc[g] & cmp_armed[g]))
        cmp_flag[g] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // compare pins
  // ---------------------------------------------------------------
  // pin one in single pulse mode: trigger starts, match one ends
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin_q[0] <= 1'b0;
    else if (pulse_mode & pulse_trig)
      pin_q[0] <= level[1];
    else if (pulse_mode & match[0])
      pin_q[0] <= level[0];
    else if (~pulse_mode & match[0] & pin_en[0])
      pin_q[0] <= level[0];
    else if (force_req[0])
      pin_q[0] <= force_lvl[0];
  end

  // pin two holds still in single pulse mode
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin_q[1] <= 1'b0;
    else if (pulse_mode)
      pin_q[1] <= pin_q[1];
    else if (match[1] & pin_en[1])
      pin_q[1] <= level[1];
    else if (force_req[1])
      pin_q[1] <= force_lvl[1];
  end

  // pin is released to the port logic when not enabled
  assign compare_output_pin_o = pin_q;
  assign compare_output_oe_o  = pin_en;

  // ---------------------------------------------------------------
  // capture functions
  // ---------------------------------------------------------------
  logic [1:0] cap_lo_acc; // capture low byte accessed
  logic [1:0] set_cap;    // hardware sets capture flag

  for (genvar g = 0; g < 2; g++) begin : g_cap
    localparam logic [7:0] LO_OFF = (g == 0) ? timer_oc_pkg::CAP_ONE_LOW_OFF
                                             : timer_oc_pkg::CAP_TWO_LOW_OFF;
    assign cap_lo_acc[g] = bus_take & (adr_i == LO_OFF);
    // pin one is cut off in width mode
    assign set_cap[g] = cap_ev[g] & ~(g == 0 & pwm_on);

    // captured value; pin one loads the fixed trigger value
    always_ff @(posedge clk_i) begin
      if (rst_i)
        cap_val[g] <= timer_oc_pkg::CAP_RESET;
      else if (g == 0 & pulse_trig)
        cap_val[g] <= timer_oc_pkg::PULSE_CAPTURE_LOAD;
      else if (set_cap[g] & ~(g == 0 & pulse_mode))
        cap_val[g] <= counter_i;
    end

    // clearing arm for the capture flag
    always_ff @(posedge clk_i) begin
      if (rst_i)
        cap_armed[g] <= 1'b0;
      else if (flag_rd)
        cap_armed[g] <= cap_flag[g];
      else if (cap_lo_acc[g])
        cap_armed[g] <= 1'b0;
    end

    // sticky capture flag, set beats clear
    always_ff @(posedge clk_i) begin
      if (rst_i)
        cap_flag[g] <= 1'b0;
      else if (set_cap[g])
        cap_flag[g] <= 1'b1;
      else if (cap_lo_acc[g] & cap_armed[g])
        cap_flag[g] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // counter reload and interrupt request
  // ---------------------------------------------------------------
  wire cmp_pend = |cmp_flag & cmp_irq_en;
  wire cap_pend = |cap_flag & cap_irq_en;

  // reload asks the counter for the trigger start value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      load_q <= pulse_trig;
      irq_q  <= ~cpu_irq_mask_i & (cmp_pend | cap_pend);
    end
  end

  assign counter_load_o = load_q;
  assign timer_irq_o    = irq_q;

  // ---------------------------------------------------------------
  // bus answer and read data
  // ---------------------------------------------------------------
  wire [7:0] rd_byte =
    (adr_i == timer_oc_pkg::CTRL_ONE_OFF)     ? ctrl_one :
    (adr_i == timer_oc_pkg::CTRL_TWO_OFF)     ? ctrl_two :
    (adr_i == timer_oc_pkg::FLAG_OFF)         ? {4'h0, cap_flag, cmp_flag} :
    (adr_i == timer_oc_pkg::CMP_ONE_HIGH_OFF) ? cmp_val[0][15:8] :
    (adr_i == timer_oc_pkg::CMP_ONE_LOW_OFF)  ? cmp_val[0][7:0] :
    (adr_i == timer_oc_pkg::CMP_TWO_HIGH_OFF) ? cmp_val[1][15:8] :
    (adr_i == timer_oc_pkg::CMP_TWO_LOW_OFF)  ? cmp_val[1][7:0] :
    (adr_i == timer_oc_pkg::CAP_ONE_HIGH_OFF) ? cap_val[0][15:8] :
    (adr_i == timer_oc_pkg::CAP_ONE_LOW_OFF)  ? cap_val[0][7:0] :
    (adr_i == timer_oc_pkg::CAP_TWO_HIGH_OFF) ? cap_val[1][15:8] :
    (adr_i == timer_oc_pkg::CAP_TWO_LOW_OFF)  ? cap_val[1][7:0] :
    8'h00;

  // one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack  <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      ack <= bus_req & ~ack;
      if (bus_req & ~ack)
        rd_q <= {24'h00_0000, rd_byte};
    end
  end

  assign ack_o = ack;
  assign dat_o = rd_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_flag_read_one;
    flag_rd && cmp_flag[0];
  endsequence

  sequence s_low_read_one;
    lo_acc[0] && !lo_wr[0] && !match[0];
  endsequence

  sequence s_pulse_start;
    pulse_trig && !match[0];
  endsequence

  a_reset_values: assert property (
    $fell(rst_i) |-> cmp_val[0] == timer_oc_pkg::CMP_RESET &&
                     cmp_val[1] == timer_oc_pkg::CMP_RESET && pin_q == 2'h0)
    else $error("compare state not at reset value");

  a_match_sets_flag: assert property (
    match[1] |=> cmp_flag[1])
    else $error("match two did not set flag");

  a_value_hold: assert property (
    !(hi_wr[0] || lo_wr[0]) |=> $stable(cmp_val[0]))
    else $error("compare value changed without a write");

  a_match_drives_pin: assert property (
    match[1] && pin_en[1] && !pulse_mode |=> pin_q[1] == $past(level[1]))
    else $error("pin two did not take its level");

  a_irq_mask_gate: assert property (
    cpu_irq_mask_i |=> !timer_irq_o)
    else $error("interrupt raised while masked");

  a_flag_clear_seq: assert property (
    s_flag_read_one ##3 s_low_read_one |=> !cmp_flag[0])
    else $error("flag one not cleared by read sequence");

  a_high_inhibits: assert property (
    hi_wr[0] |=> inhibit[0] && !match[0])
    else $error("high write did not inhibit compare");

  a_low_reenables: assert property (
    lo_wr[1] && !match[1] |=> !cmp_flag[1] && !inhibit[1])
    else $error("low write did not re-enable compare");

  a_force_no_flag: assert property (
    force_req[0] && !match[0] && !cmp_flag[0]
      |=> pin_q[0] == level[0] && !cmp_flag[0])
    else $error("force did not copy level or set a flag");

  a_pulse_start: assert property (
    s_pulse_start |=> counter_load_o && cap_flag[0] && pin_q[0] == $past(level[1])
                      && cap_val[0] == timer_oc_pkg::PULSE_CAPTURE_LOAD)
    else $error("pulse start incomplete");

  a_pulse_end: assert property (
    pulse_mode && match[0] && !pulse_trig |=> pin_q[0] == $past(level[0]))
    else $error("pulse not ended on match one");

  a_no_flag_one: assert property (
    pulse_mode && !cmp_flag[0] |=> !cmp_flag[0])
    else $error("flag one set in single pulse mode");
endmodule

// *** rtl/timer_oc_pkg.sv ***
// register map, field positions and reset values of the output compare block
package timer_oc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets, one word each
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_OFF     = 8'h00;
  localparam logic [7:0] CTRL_TWO_OFF     = 8'h04;
  localparam logic [7:0] FLAG_OFF         = 8'h08;
  localparam logic [7:0] CMP_ONE_HIGH_OFF = 8'h0c;
  localparam logic [7:0] CMP_ONE_LOW_OFF  = 8'h10;
  localparam logic [7:0] CMP_TWO_HIGH_OFF = 8'h14;
  localparam logic [7:0] CMP_TWO_LOW_OFF  = 8'h18;
  localparam logic [7:0] CAP_ONE_HIGH_OFF = 8'h1c;
  localparam logic [7:0] CAP_ONE_LOW_OFF  = 8'h20;
  localparam logic [7:0] CAP_TWO_HIGH_OFF = 8'h24;
  localparam logic [7:0] CAP_TWO_LOW_OFF  = 8'h28;
  // ---------------------------------------------------------------
  // timer_control_one fields
  // ---------------------------------------------------------------
  localparam int LVL_ONE_BIT   = 0;
  localparam int LVL_TWO_BIT   = 1;
  localparam int FORCE_ONE_BIT = 2;
  localparam int FORCE_TWO_BIT = 3;
  localparam int EDGE_ONE_BIT  = 4;
  localparam int CMP_IRQ_BIT   = 5;
  localparam int CAP_IRQ_BIT   = 6;
  // ---------------------------------------------------------------
  // timer_control_two fields
  // ---------------------------------------------------------------
  localparam int PIN_EN_ONE_BIT   = 0;
  localparam int PIN_EN_TWO_BIT   = 1;
  localparam int SINGLE_PULSE_BIT = 2;
  localparam int PWM_BIT          = 3;
  localparam int EDGE_TWO_BIT     = 4;
  // ---------------------------------------------------------------
  // write masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_ONE_WMASK     = 8'h73;
  localparam logic [7:0]  CTRL_TWO_WMASK     = 8'h1f;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [15:0] CMP_RESET          = 16'h8000;
  localparam logic [15:0] CAP_RESET          = 16'h0000;
  localparam logic [15:0] PULSE_COUNT_LOAD   = 16'hfffc;
  localparam logic [15:0] PULSE_CAPTURE_LOAD = 16'hfffd;
endpackage

// *** rtl/capture_edge_if.sv ***
// filtered levels and edge pulses of the two capture pins
interface capture_edge_if;
  logic [1:0] level; // filtered pin level
  logic [1:0] rise;  // one-cycle rising edge pulse
  logic [1:0] fall;  // one-cycle falling edge pulse
  modport source (output level, rise, fall);
  modport sink   (input level, rise, fall);
endinterface

// *** rtl/pin_edge_sync.sv ***
// three-stage synchroniser and edge detector for the capture pins
module pin_edge_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pin_i,
  capture_edge_if.source  edges
);
  // ---------------------------------------------------------------
  // per pin synchroniser
  // ---------------------------------------------------------------
  logic [1:0] s1;     // first stage, read only by s2
  logic [1:0] s2;     // second stage
  logic [1:0] s3;     // third stage
  logic [1:0] lvl;    // agreed level
  logic [1:0] primed; // first agreement after reset seen
  logic [1:0] rise_q; // rising edge pulse
  logic [1:0] fall_q; // falling edge pulse

  for (genvar g = 0; g < 2; g++) begin : g_pin
    // a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1[g]     <= 1'b0;
        s2[g]     <= 1'b0;
        s3[g]     <= 1'b0;
        lvl[g]    <= 1'b0;
        primed[g] <= 1'b0;
        rise_q[g] <= 1'b0;
        fall_q[g] <= 1'b0;
      end else begin
        s1[g] <= pin_i[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g]) begin
          // first agreement only loads the level, no false edge
          primed[g] <= 1'b1;
          lvl[g]    <= s3[g];
          rise_q[g] <= primed[g] & s3[g] & ~lvl[g];
          fall_q[g] <= primed[g] & ~s3[g] & lvl[g];
        end else begin
          rise_q[g] <= 1'b0;
          fall_q[g] <= 1'b0;
        end
      end
    end
  end

  assign edges.level = lvl;
  assign edges.rise  = rise_q;
  assign edges.fall  = fall_q;
endmodule

// *** test/pin_partner.sv ***
// far-side model: counter block feeding the compare logic and the capture pin drivers
module pin_partner (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        load_i,
  output logic      [15:0] count_o,
  output logic      [1:0]  pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // free running counter, restarts at fffch on reset or trigger load
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || load_i) begin
      count_o <= timer_oc_pkg::PULSE_COUNT_LOAD;
    end else begin
      count_o <= count_o + 16'h0001;
    end
  end
  // pins idle low so the first sample after reset is no edge
  initial pins_o = 2'b00;
  // raise both capture pins just after an edge
  task automatic raise_pins();
    @(posedge clk_i);
    pins_o <= 2'b11;
  endtask
endmodule

// *** test/timer_output_compare_tb.sv ***
// self-checking bench for the output compare and single pulse block
module timer_output_compare_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        irq_mask;
  logic [7:0]  adr;
  logic [3:0]  sel;      // byte select on the bus
  logic [3:0]  wsel;     // byte select the next request will carry
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] count;
  logic [1:0]  cap_pins;
  logic [1:0]  pin_o;
  logic [1:0]  oe_o;
  logic        load;
  logic        irq_o;
  logic [15:0] dur;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          seed = 83;
  int          n;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  timer_output_compare u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .counter_i(count),
    .cpu_irq_mask_i(irq_mask), .capture_input_one_i(cap_pins[0]),
    .capture_input_two_i(cap_pins[1]), .compare_output_pin_o(pin_o),
    .compare_output_oe_o(oe_o), .counter_load_o(load), .timer_irq_o(irq_o));
  pin_partner u_partner (
    .clk_i(clk_i), .rst_i(rst_i), .load_i(load), .count_o(count), .pins_o(cap_pins));
  // clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // read monitor: each answered read takes the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check("read data", dat_o, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // bus and wait helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    wdat <= d;
    // hold until ack is sampled high; only the hang guard ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_count(input logic [15:0] v);
    while (count !== v) begin
      @(posedge clk_i);
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hf;
    wsel = 4'hf;
    adr = 8'h00;
    wdat = 32'h0;
    irq_mask = 1'b1;
    repeat (2) @(posedge clk_i);
    check("pins in reset", 32'({oe_o, pin_o}), 32'h0);
    rst_i <= 1'b0;
    rd(timer_oc_pkg::CMP_ONE_HIGH_OFF, 32'h80);
    rd(timer_oc_pkg::CMP_TWO_HIGH_OFF, 32'h80);
    rd(timer_oc_pkg::CMP_TWO_LOW_OFF, 32'h00);
    rd(8'h3c, 32'h0);
    wr(timer_oc_pkg::CMP_ONE_HIGH_OFF, 32'h01);
    wr(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'h20);
    rd(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'h20);
    // a write without byte lane zero is ignored
    wsel = 4'h0;
    wr(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'h55);
    wsel = 4'hf;
    rd(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'h20);
    wr(timer_oc_pkg::CTRL_ONE_OFF, 32'h01);
    wr(timer_oc_pkg::CTRL_TWO_OFF, 32'h01);
    // match drives pin one and sets its flag, then two-step clear
    wait_count(16'h0130);
    check("pin one on match", 32'(pin_o[0]), 32'h1);
    rd(timer_oc_pkg::FLAG_OFF, 32'h01);
    rd(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'h20);
    rd(timer_oc_pkg::FLAG_OFF, 32'h00);
    // high byte alone inhibits compare two
    wr(timer_oc_pkg::CMP_TWO_HIGH_OFF, 32'h02);
    wait_count(16'h0230);
    rd(timer_oc_pkg::FLAG_OFF, 32'h00);
    wr(timer_oc_pkg::CMP_TWO_LOW_OFF, 32'h80);
    wr(timer_oc_pkg::CTRL_ONE_OFF, 32'h23);
    wait_count(16'h0290);
    check("pin two disabled", 32'(pin_o[1]), 32'h0);
    rd(timer_oc_pkg::FLAG_OFF, 32'h02);
    check("masked irq", 32'(irq_o), 32'h0);
    irq_mask <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("irq", 32'(irq_o), 32'h1);
    // pin two enabled: next match drives its level
    wr(timer_oc_pkg::CTRL_TWO_OFF, 32'h03);
    wr(timer_oc_pkg::CMP_TWO_LOW_OFF, 32'hc0);
    wait_count(16'h02d0);
    check("pin two on match", 32'(pin_o[1]), 32'h1);
    wr(timer_oc_pkg::CMP_TWO_LOW_OFF, 32'h80);
    rd(timer_oc_pkg::FLAG_OFF, 32'h00);
    // force one with low level, no flag
    wr(timer_oc_pkg::CTRL_ONE_OFF, 32'h04);
    repeat (2) @(posedge clk_i);
    check("forced pin", 32'({oe_o, pin_o}), 32'he);
    rd(timer_oc_pkg::FLAG_OFF, 32'h00);
    // single pulse with random duration
    dur = 16'h0010 + 16'($random(seed) & 32'h1f);
    wr(timer_oc_pkg::CMP_ONE_HIGH_OFF, 32'(dur[15:8]));
    wr(timer_oc_pkg::CMP_ONE_LOW_OFF, 32'(dur[7:0]));
    wr(timer_oc_pkg::CTRL_ONE_OFF, 32'h52);
    wr(timer_oc_pkg::CTRL_TWO_OFF, 32'h15);
    u_partner.raise_pins();
    n = 0;
    while (pin_o[0] !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (pin_o[0] === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check("pulse width", 32'(n >= dur + 4 && n <= dur + 7), 32'h1);
    check("irq on trigger", 32'(irq_o), 32'h1);
    rd(timer_oc_pkg::CAP_ONE_HIGH_OFF, 32'hff);
    rd(timer_oc_pkg::CAP_ONE_LOW_OFF, 32'hfd);
    rd(timer_oc_pkg::FLAG_OFF, 32'h0c);
    wr(timer_oc_pkg::CTRL_ONE_OFF, 32'h57);
    repeat (2) @(posedge clk_i);
    check("force in pulse mode", 32'(pin_o[0]), 32'h0);
    wrap_up();
  end
endmodule
